// File: src/sdp_consts.vh
// constants for the split dual byte pwm timer: offsets, fields, resets
// assumes a 32-bit avalon-mm slave with word addressing by byte offset
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH
`define SDP_ADDR_W        8
`define SDP_OFS_CTRL      8'h00
`define SDP_OFS_PRESC     8'h04
`define SDP_OFS_PER       8'h08
`define SDP_OFS_CMP_LO    8'h0C
`define SDP_OFS_CMP_HI    8'h10
`define SDP_OFS_FLAGS     8'h14
`define SDP_OFS_INTEN     8'h18
`define SDP_OFS_COUNT     8'h1C
`define SDP_OFS_WORD16    8'h20
`define SDP_CTRL_EN       0
`define SDP_CTRL_SPLIT    1
`define SDP_CTRL_EVSRC    2
`define SDP_RST_PER       8'hFF
`define SDP_RST_PER16     16'hFFFF
`define SDP_RST_PRESC     16'h0000
`endif

// File: src/sdp_cnt8.v
// one 8-bit down-counter with four compare channels
// assumes tick is a one-cycle advance strobe in the sys_clk domain
`timescale 1ns/1ps
module sdp_cnt8 #(
  parameter W = 8
) (
  input  wire           sys_clk,
  input  wire           nrst,
  input  wire           run,
  input  wire           tick,
  input  wire [W-1:0]   per,
  input  wire [4*W-1:0] cmp,
  output reg  [W-1:0]   cnt_q,
  output reg  [3:0]     pwm_q,
  output reg            unf_q,
  output reg  [3:0]     match_q
);
  integer i;
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q   <= {W{1'b0}};
      pwm_q   <= 4'h0;
      unf_q   <= 1'b0;
      match_q <= 4'h0;
    end
    else
    begin
      unf_q   <= 1'b0;
      match_q <= 4'h0;
      if (!run)
        cnt_q <= per;
      else if (tick)
      begin
        if (cnt_q == {W{1'b0}})
        begin
          cnt_q <= per;
          unf_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        for (i = 0; i < 4; i = i + 1)
          match_q[i] <= (cnt_q == cmp[i*W +: W]);
      end
      for (i = 0; i < 4; i = i + 1)
        pwm_q[i] <= run && (cmp[i*W +: W] > cnt_q);
    end
  end
endmodule // sdp_cnt8

// File: src/sdp_top.v
// split dual byte pwm timer with avalon-mm register slave
// assumes synchronous inputs on sys_clk, async active-low nrst
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sdp_consts.vh"
module sdp_top #(
  parameter PRESC_W = 16
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        count_event,
  output reg  [7:0]  pwm_out_q,
  output reg         irq_q,
  output reg  [4:0]  event_out_q,
  output reg  [3:0]  dma_req_q
);
  reg  [2:0]          ctrl_q;
  reg  [PRESC_W-1:0]  presc_q;
  reg  [15:0]         per_q;
  reg  [31:0]         cmp_lo_q;
  reg  [31:0]         cmp_hi_q;
  reg  [5:0]          flags_q;
  reg  [5:0]          inten_q;
  reg  [PRESC_W-1:0]  div_q;
  reg                 tick_q;
  reg  [15:0]         cnt16_q;
  reg  [3:0]          pwm16_q;
  reg                 unf16_q;
  reg                 ack_q;
  wire [7:0]          lo_cnt;
  wire [7:0]          hi_cnt;
  wire [3:0]          lo_pwm;
  wire [3:0]          hi_pwm;
  wire [3:0]          lo_match;
  wire                lo_unf;
  wire                hi_unf;
  wire                en;
  wire                split;
  wire                run_split;
  wire                run16;
  wire                wr;
  wire [31:0]         wmask;
  wire [5:0]          fset;
  wire [31:0]         ctrl_m;
  wire [31:0]         presc_m;
  wire [31:0]         per_m;
  wire [31:0]         inten_m;

  function [31:0] bemask;
    input [3:0] be;
    begin
      bemask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  assign en        = ctrl_q[`SDP_CTRL_EN];
  assign split     = ctrl_q[`SDP_CTRL_SPLIT];
  assign run_split = en && split;
  assign run16     = en && !split;
  assign wr        = avs_write && ack_q;
  assign wmask     = bemask(avs_byteenable);
  assign ctrl_m    = merge({29'h0, ctrl_q}, avs_writedata, wmask);
  assign presc_m   = merge({{(32-PRESC_W){1'b0}}, presc_q}, avs_writedata, wmask);
  assign per_m     = merge({16'h0, per_q}, avs_writedata, wmask);
  assign inten_m   = merge({26'h0, inten_q}, avs_writedata, wmask);

  ////////////////////////////////////////////////////////////////////////
  // shared tick source
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q  <= {PRESC_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (!en)
    begin
      div_q  <= {PRESC_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (ctrl_q[`SDP_CTRL_EVSRC])
    begin
      div_q  <= {PRESC_W{1'b0}};
      tick_q <= count_event;
    end
    else if (div_q >= presc_q)
    begin
      div_q  <= {PRESC_W{1'b0}};
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + {{(PRESC_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // split counters
  sdp_cnt8 #(.W(8)) u_lo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .run     (run_split),
    .tick    (tick_q),
    .per     (per_q[7:0]),
    .cmp     (cmp_lo_q),
    .cnt_q   (lo_cnt),
    .pwm_q   (lo_pwm),
    .unf_q   (lo_unf),
    .match_q (lo_match)
  );

  sdp_cnt8 #(.W(8)) u_hi (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .run     (run_split),
    .tick    (tick_q),
    .per     (per_q[15:8]),
    .cmp     (cmp_hi_q),
    .cnt_q   (hi_cnt),
    .pwm_q   (hi_pwm),
    .unf_q   (hi_unf),
    .match_q ()
  );

  ////////////////////////////////////////////////////////////////////////
  // normal 16-bit timer, down counting, compares from the four 16-bit halves of cmp_lo_q and cmp_hi_q
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt16_q <= 16'h0000;
      pwm16_q <= 4'h0;
      unf16_q <= 1'b0;
    end
    else
    begin
      unf16_q <= 1'b0;
      if (!run16)
        cnt16_q <= per_q;
      else if (tick_q)
      begin
        if (cnt16_q == 16'h0000)
        begin
          cnt16_q <= per_q;
          unf16_q <= 1'b1;
        end
        else
          cnt16_q <= cnt16_q - 16'h0001;
      end
      pwm16_q[0] <= run16 && (cmp_lo_q[15:0] > cnt16_q);
      pwm16_q[1] <= run16 && (cmp_lo_q[31:16] > cnt16_q);
      pwm16_q[2] <= run16 && (cmp_hi_q[15:0] > cnt16_q);
      pwm16_q[3] <= run16 && (cmp_hi_q[31:16] > cnt16_q);
    end
  end

  // flags: [3:0] low compares, [4] low/16-bit underflow, [5] high underflow
  assign fset = {hi_unf, lo_unf | unf16_q, lo_match};

  ////////////////////////////////////////////////////////////////////////
  // avalon-mm slave, one wait cycle per access
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q          <= 3'h0;
      presc_q         <= `SDP_RST_PRESC;
      per_q           <= `SDP_RST_PER16;
      cmp_lo_q        <= 32'h00000000;
      cmp_hi_q        <= 32'h00000000;
      flags_q         <= 6'h00;
      inten_q         <= 6'h00;
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      pwm_out_q       <= 8'h00;
      irq_q           <= 1'b0;
      event_out_q     <= 5'h00;
      dma_req_q       <= 4'h0;
    end
    else
    begin
      ack_q           <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
      if (wr)
      begin
        case (avs_address)
          `SDP_OFS_CTRL:   ctrl_q   <= ctrl_m[2:0];
          `SDP_OFS_PRESC:  presc_q  <= presc_m[PRESC_W-1:0];
          `SDP_OFS_PER:    per_q    <= per_m[15:0];
          `SDP_OFS_CMP_LO: cmp_lo_q <= merge(cmp_lo_q, avs_writedata, wmask);
          `SDP_OFS_CMP_HI: cmp_hi_q <= merge(cmp_hi_q, avs_writedata, wmask);
          `SDP_OFS_INTEN:  inten_q  <= inten_m[5:0];
          default:         ;
        endcase
      end
      // write one to clear, hardware set wins
      if (wr && avs_address == `SDP_OFS_FLAGS && avs_byteenable[0])
        flags_q <= (flags_q & ~avs_writedata[5:0]) | fset;
      else
        flags_q <= flags_q | fset;
      if (avs_read && !ack_q)
      begin
        case (avs_address)
          `SDP_OFS_CTRL:   avs_readdata <= {29'h0, ctrl_q};
          `SDP_OFS_PRESC:  avs_readdata <= {{(32-PRESC_W){1'b0}}, presc_q};
          `SDP_OFS_PER:    avs_readdata <= {16'h0, per_q};
          `SDP_OFS_CMP_LO: avs_readdata <= cmp_lo_q;
          `SDP_OFS_CMP_HI: avs_readdata <= cmp_hi_q;
          `SDP_OFS_FLAGS:  avs_readdata <= {26'h0, flags_q};
          `SDP_OFS_INTEN:  avs_readdata <= {26'h0, inten_q};
          `SDP_OFS_COUNT:  avs_readdata <= {16'h0, hi_cnt, lo_cnt};
          `SDP_OFS_WORD16: avs_readdata <= {16'h0, cnt16_q};
          default:         avs_readdata <= 32'h00000000;
        endcase
      end
      pwm_out_q   <= split ? {hi_pwm, lo_pwm} : {4'h0, pwm16_q};
      irq_q       <= |(flags_q & inten_q);
      event_out_q <= {lo_unf | unf16_q, lo_match};
      dma_req_q   <= lo_match;
    end
  end
endmodule // sdp_top

// File: verification/sdp_checker.sv
// checker: bus handshake and output relations of sdp_top
// assumes top-level ports only; bound after endmodule
`timescale 1ns/1ps
`include "sdp_consts.vh"
module sdp_checker (
  input wire        sys_clk,
  input wire        nrst,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        count_event,
  input wire [7:0]  pwm_out_q,
  input wire        irq_q,
  input wire [4:0]  event_out_q,
  input wire [3:0]  dma_req_q
);
  reg  en_q, split_q, ev_q, inz_q;
  wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  // shadow of control and interrupt enable
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
      {en_q, split_q, ev_q, inz_q} <= 4'h1;
    else if (wr && avs_address == `SDP_OFS_CTRL)
      {ev_q, split_q, en_q} <= avs_writedata[2:0];
    else if (wr && avs_address == `SDP_OFS_INTEN)
      inz_q <= avs_writedata[5:0] == 6'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  sequence s_req; $rose(avs_read || avs_write); endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  sequence s_off; !en_q [*4]; endsequence
  AST_ACK:
    assert property (s_req |=> s_ack) else $error("ack not one cycle");
  AST_RDATA:
    assert property ($changed(avs_readdata) |-> $fell(avs_waitrequest) && avs_read)
      else $error("read data moved");
  AST_UNMAPPED:
    assert property (avs_read && !avs_waitrequest && avs_address > 8'h20
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  AST_DMA_EVT:
    assert property (dma_req_q == event_out_q[3:0]) else $error("dma differs from events");
  AST_NORMAL_HI:
    assert property (!split_q [*4] |-> pwm_out_q[7:4] == 4'h0) else $error("high pwm in normal");
  AST_IDLE:
    assert property (s_off |-> event_out_q == 5'h00 && dma_req_q == 4'h0)
      else $error("pulse while disabled");
  AST_EVQUIET:
    assert property ((en_q && ev_q && !count_event) [*4] |-> event_out_q == 5'h00)
      else $error("count without event");
  AST_IRQ:
    assert property (inz_q [*3] |-> !irq_q) else $error("irq while masked");
endmodule // sdp_checker
bind sdp_top sdp_checker i_sdp_checker (.sys_clk, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .count_event, .pwm_out_q, .irq_q, .event_out_q, .dma_req_q);

// File: verification/sdp_top_bench.sv
// bench for sdp_top: registers, split pwm, counting, events, irq
// assumes sdp_checker bound to sdp_top
`timescale 1ns/1ps
`include "sdp_consts.vh"
module sdp_top_bench;
  reg         sys_clk, nrst, avs_read, avs_write, count_event;
  reg  [7:0]  avs_address;
  reg  [31:0] avs_writedata, rd;
  reg  [3:0]  avs_byteenable;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, irq_q;
  wire [7:0]  pwm_out_q;
  wire [4:0]  event_out_q;
  wire [3:0]  dma_req_q;
  integer     mismatches, check_count, nu, nd, e, i;
  sdp_top i_sdp_top (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .count_event, .pwm_out_q, .irq_q, .event_out_q, .dma_req_q);
  ////////////////////////////////////////
  task results;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input string s, input [31:0] x, input [31:0] g);
  begin
    check_count = check_count + 1;
    if (g !== x)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s exp %h got %h", s, x, g);
    end
  end
  endtask
  task acc(input w, input [7:0] a, input [31:0] d);
    integer n;
  begin
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    while (avs_waitrequest !== 1'h0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge sys_clk);
    if (n >= 20)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end
  endtask
  task cnt(input integer c);
  begin
    nu = 0;
    nd = 0;
    repeat (c)
    begin
      @(posedge sys_clk);
      nu = nu + event_out_q[4];
      nd = nd + dma_req_q[0];
    end
  end
  endtask
  ////////////////////////////////////////
  task t_reset;
  begin
    chk("wait", 32'h1, avs_waitrequest);
    acc(1'h0, `SDP_OFS_PER, 32'h0);
    chk("per", 32'h0000FFFF, rd);
    avs_byteenable <= 4'h2;
    acc(1'h1, `SDP_OFS_PER, 32'h0000AB00);
    avs_byteenable <= 4'hF;
    acc(1'h0, `SDP_OFS_PER, 32'h0);
    chk("per lane", 32'h0000ABFF, rd);
    acc(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
  end
  endtask
  task t_pwm;
  begin
    acc(1'h1, `SDP_OFS_PRESC, 32'h100);
    acc(1'h1, `SDP_OFS_PER, 32'h0303);
    acc(1'h1, `SDP_OFS_CMP_LO, 32'h04020100);
    acc(1'h1, `SDP_OFS_CMP_HI, 32'h04040404);
    acc(1'h1, `SDP_OFS_CTRL, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk("pwm", 32'hF8, {24'h0, pwm_out_q});
    acc(1'h1, `SDP_OFS_CTRL, 32'h2);
    acc(1'h0, `SDP_OFS_COUNT, 32'h0);
    chk("count", 32'h00000303, rd);
    chk("pwm off", 32'h0, {24'h0, pwm_out_q});
  end
  endtask
  task t_run(input [31:0] p);
  begin
    acc(1'h1, `SDP_OFS_PRESC, p);
    acc(1'h1, `SDP_OFS_CTRL, 32'h3);
    cnt(48);
    acc(1'h1, `SDP_OFS_CTRL, 32'h2);
    e = 48 / (4 * (p + 1));
    chk("unf", 32'h1, nu >= e - 1 && nu <= e + 1);
    chk("dma", 32'h1, nd >= e - 1 && nd <= e + 1);
  end
  endtask
  task t_event;
  begin
    acc(1'h1, `SDP_OFS_CTRL, 32'h7);
    repeat (4) @(posedge sys_clk);
    nu = 0;
    for (i = 0; i < 22; i = i + 1)
    begin
      count_event <= i < 16 && !i[0];
      @(posedge sys_clk);
      nu = nu + event_out_q[4];
    end
    chk("evt unf", 32'h2, nu);
    acc(1'h1, `SDP_OFS_CTRL, 32'h2);
  end
  endtask
  task t_irq;
  begin
    acc(1'h0, `SDP_OFS_FLAGS, 32'h0);
    chk("flags", 32'h30, rd & 32'h30);
    acc(1'h1, `SDP_OFS_INTEN, 32'h10);
    repeat (3) @(posedge sys_clk);
    chk("irq", 32'h1, irq_q);
    acc(1'h1, `SDP_OFS_FLAGS, 32'h3F);
    repeat (3) @(posedge sys_clk);
    chk("irq", 32'h0, irq_q);
    acc(1'h0, `SDP_OFS_FLAGS, 32'h0);
    chk("clear", 32'h0, rd & 32'h3F);
  end
  endtask
  task t_normal;
  begin
    acc(1'h1, `SDP_OFS_PER, 32'h3);
    acc(1'h1, `SDP_OFS_CTRL, 32'h1);
    cnt(48);
    chk("pwm16", 32'hF, {28'h0, pwm_out_q[3:0]});
    acc(1'h1, `SDP_OFS_CTRL, 32'h0);
    chk("unf16", 32'h1, nu >= 11 && nu <= 13);
    chk("hi", 32'h0, {28'h0, pwm_out_q[7:4]});
    acc(1'h0, `SDP_OFS_WORD16, 32'h0);
    chk("count16", 32'h3, rd);
    acc(1'h0, `SDP_OFS_FLAGS, 32'h0);
    chk("flags16", 32'h10, rd & 32'h30);
    chk("irq", 32'h1, irq_q);
  end
  endtask
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {nrst, avs_read, avs_write, count_event} = 4'h0;
    {avs_address, avs_writedata, rd} = 72'h0;
    avs_byteenable = 4'hF;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
    t_reset;
    t_pwm;
    t_run(32'h1);
    t_run(32'h0);
    t_event;
    t_irq;
    t_normal;
    results;
  end
endmodule // sdp_top_bench
